// *** common/jcpp_pkg.sv ***
package jcpp_pkg;

  // Clock and test clock timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int TCK_HALF_NS = 100;
  localparam int TCK_HALF_CYC = (TCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_W = 4;

  // Chain limits
  localparam int DEV_W = 5;
  localparam int IRB_W = 9;
  localparam int IRT_W = 4;
  localparam int IDX_W = 10;
  localparam logic [DEV_W-1:0] DEV_MAX = 5'h0f;
  localparam logic [IDX_W-1:0] IR_TOTAL_MAX = 10'h100;

  // Payload
  localparam int LEN_W = 5;
  localparam int DATA_W = 32;

  // Test mode select patterns, sent lsb first
  localparam int HIDX_W = 3;
  localparam logic [7:0] HEAD_IR = 8'h03;
  localparam logic [HIDX_W-1:0] HEAD_IR_LAST = 3'h3;
  localparam logic [7:0] HEAD_DR = 8'h01;
  localparam logic [HIDX_W-1:0] HEAD_DR_LAST = 3'h2;
  localparam logic [7:0] HEAD_RST = 8'h1f;
  localparam logic [HIDX_W-1:0] HEAD_RST_LAST = 3'h5;
  localparam logic [7:0] TAIL_PAT = 8'h01;
  localparam logic [HIDX_W-1:0] TAIL_LAST = 3'h1;

  // Trace capture
  localparam int BYTE_W = 8;
  localparam int TDIV_W = 8;
  localparam int TRACE_BYTES_PER_S = 3_000_000;
  localparam int TRACE_FRAME_BITS = 10;
  localparam int TRACE_CALC_DIV = CLK_HZ / (TRACE_BYTES_PER_S * TRACE_FRAME_BITS);
  localparam logic [TDIV_W-1:0] TRACE_MIN_DIV = (TRACE_CALC_DIV < 2) ? 8'h02 : TDIV_W'(TRACE_CALC_DIV);
  localparam logic [2:0] TRACE_LAST_BIT = 3'h7;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    OP_TAP_RESET = 2'b00,
    OP_IR = 2'b01,
    OP_DR = 2'b10,
    OP_SWD = 2'b11
  } jcpp_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TAIL = 2'b11
  } jcpp_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } jcpp_rx_t;

endpackage : jcpp_pkg

// *** common/jcpp_stream_if.sv ***
`timescale 1ns/1ps
interface jcpp_stream_if #(parameter int WIDTH = 8) ();
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo (input wr_valid, input wr_data, input rd_ready, output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready, input wr_ready, input rd_valid, input rd_data);
endinterface : jcpp_stream_if

// *** dv/jcpp_chain_model.sv ***
`timescale 1ns/1ps
module jcpp_chain_model #(parameter int D = 8) (
  input wire logic tck, // Test clock
  input wire logic tms, // Mode select
  input wire logic tdi, // Serial data in
  input wire logic oe, // Probe drives mode line
  input wire logic [31:0] rd_word, // Serial-wire read bits
  output logic tdo, // Serial data out
  output logic tms_in // Mode line level
);
  localparam logic [63:0] HI = 64'h2fefcc0287855920;
  localparam logic [63:0] LO = 64'h1bddbba146644311;
  logic [3:0] st = 4'h0;
  logic [D-1:0] sr = '0;
  int n = 0;
  initial tdo = 1'b1;
  always @(posedge tck)
  begin
    if (st == 4'h4 || st == 4'hb)
      sr <= {sr[D-2:0], tdi};
    st <= tms ? HI[4*st+:4] : LO[4*st+:4];
  end
  // Released line toggles so a stale level never passes
  always @(negedge tck)
    tdo <= (st inside {4'h3, 4'h4, 4'ha, 4'hb}) ? sr[D-1] : ~tdo;
  always @(posedge tck or posedge oe)
    n <= oe ? 0 : n + 1;
  assign tms_in = oe ? tms : rd_word[n[4:0]];
endmodule : jcpp_chain_model

// *** dv/tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end
module tb;
  logic clk = 0, reset_n = 0, swd_mode = 0, cfg_valid = 0, cmd_valid = 0, cmd_swd_drive = 0;
  logic sys_req = 0, tap_req = 0, trace_en = 0, trace_ready = 0, uart = 1, ce = 1, hold;
  logic [4:0] db = 0, da = 0, len = 0;
  logic [8:0] ib = 0, ia = 0;
  logic [3:0] it = 0;
  logic [31:0] data = 0, rd_word = 0, d;
  logic [7:0] lf = 8'h16;
  logic [7:0] tdiv = 8'h04;
  jcpp_pkg::jcpp_op_t op = jcpp_pkg::OP_TAP_RESET;
  logic cfg_ok, cfg_err, cmd_ready, rsp_valid, tck, tms, oe, tms_in, tdi, ctdo, tapn, sysn, tv, tov;
  logic [31:0] rsp;
  logic [7:0] tdat;
  int n_mismatch = 0, tests_run = 0;
  bit cm[$], dq[$], mq[$];
  logic [7:0] tq[$];
  jcpp_port jcpp_port_inst (.clk, .reset_n, .clk_en(ce), .swd_mode, .cfg_valid, .cfg_dev_before(db),
    .cfg_dev_after(da), .cfg_ir_before(ib), .cfg_ir_after(ia), .cfg_ir_target(it), .cfg_ok, .cfg_err,
    .cmd_valid, .cmd_ready, .cmd_op(op), .cmd_swd_drive, .cmd_len(len), .cmd_data(data), .rsp_valid,
    .rsp_data(rsp), .sys_reset_req(sys_req), .tap_reset_req(tap_req), .tck_out(tck), .tms_out(tms),
    .tms_oe(oe), .tms_in, .tdi_out(tdi), .tdo_in(trace_en ? uart : ctdo), .tap_reset_out_n(tapn),
    .system_reset_out_n(sysn), .trace_en, .trace_div(tdiv), .trace_valid(tv), .trace_ready,
    .trace_data(tdat), .trace_overrun(tov));
  jcpp_chain_model #(.D(8)) jcpp_chain_model_inst (.tck, .tms, .tdi, .oe, .rd_word, .tdo(ctdo), .tms_in);
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge tck) dq.push_back(tdi);
  always @(posedge tck) mq.push_back(tms);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction : rnd
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task results();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic cfg(logic [4:0] b, logic [4:0] a, logic [8:0] x, logic [8:0] y, logic [3:0] t, logic ok);
    db = b;
    da = a;
    ib = x;
    ia = y;
    it = t;
    cfg_valid = 1;
    tick(1);
    cfg_valid = 0;
    tick(1);
    `CHK("cfg_ok", ok, cfg_ok)
    `CHK("cfg_err", ~ok, cfg_err)
  endtask : cfg
  task automatic run(jcpp_pkg::jcpp_op_t o, logic [4:0] n, logic [31:0] v);
    int k;
    op = o;
    len = n;
    data = v;
    dq = {};
    mq = {};
    cmd_valid = 1;
    k = 0;
    do @(posedge clk); while (cmd_ready !== 1'b1 && ++k < 50);
    #1 cmd_valid = 0;
    while (rsp_valid !== 1'b1) tick(1);
  endtask : run
  // Chain queue mirrors the partner's shift path, front bit leaves first
  task automatic jshift(jcpp_pkg::jcpp_op_t o, int h, int a, int b, int nb, logic [31:0] v);
    bit out[$];
    logic [31:0] e;
    e = '0;
    run(o, 5'(nb - 1), v);
    repeat (a) out.push_back(1'b1);
    for (int i = 0; i < nb; i++) out.push_back(v[i]);
    repeat (b) out.push_back(1'b1);
    foreach (out[i])
    begin
      if (i >= a && i < a + nb) e[i - a] = cm[0];
      void'(cm.pop_front());
      cm.push_back(out[i]);
      `CHK("tdi", out[i], dq[h + i])
    end
    if (o == jcpp_pkg::OP_DR) `CHK("rsp", e, rsp & ~(32'hffffffff << nb))
  endtask : jshift
  task automatic ub(logic [7:0] b, int k);
    uart = 0;
    tick(k);
    for (int i = 0; i < 8; i++)
    begin
      uart = b[i];
      tick(k);
    end
    uart = 1;
    tick(2 * k);
  endtask : ub
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2_000_000;
    n_mismatch++;
    results();
  end
  initial
  begin
    repeat (8) cm.push_back(1'b0);
    tick(6);
    reset_n = 1;
    `CHK("sysn", 1'b1, sysn)
    `CHK("tapn", 1'b1, tapn)
    cfg(5'h0f, 5'h0f, 9'h000, 9'h000, 4'h4, 1'b1);
    cfg(5'h00, 5'h10, 9'h000, 9'h000, 4'h4, 1'b0);
    cfg(5'h00, 5'h00, 9'h0fc, 9'h000, 4'h4, 1'b1);
    cfg(5'h10, 5'h00, 9'h000, 9'h000, 4'h4, 1'b0);
    cfg(5'h00, 5'h00, 9'h0fc, 9'h001, 4'h4, 1'b0);
    op = jcpp_pkg::OP_DR;
    cmd_valid = 1;
    tick(1);
    `CHK("cmd_ready", 1'b0, cmd_ready)
    cmd_valid = 0;
    cfg(5'h02, 5'h01, 9'h008, 9'h005, 4'h4, 1'b1);
    run(jcpp_pkg::OP_TAP_RESET, 5'h00, 32'h0);
    repeat (3)
    begin
      d = {rnd(), rnd(), rnd(), rnd()};
      jshift(jcpp_pkg::OP_DR, 3, 1, 2, int'(rnd() & 8'h1f) + 1, d);
    end
    jshift(jcpp_pkg::OP_IR, 4, 5, 8, 4, {24'h0, rnd()});
    sys_req = 1;
    tap_req = 1;
    tick(2);
    `CHK("tapn", 1'b0, tapn)
    fork
      jshift(jcpp_pkg::OP_DR, 3, 1, 2, 8, 32'h0000_00a5);
      begin
        tick(20);
        ce = 0;
        hold = tck;
        tick(6);
        `CHK("tck_hold", hold, tck)
        ce = 1;
      end
    join
    `CHK("sysn", 1'b0, sysn)
    sys_req = 0;
    tap_req = 0;
    tick(2);
    `CHK("sysn", 1'b1, sysn)
    swd_mode = 1;
    rd_word = {rnd(), rnd(), rnd(), rnd()};
    run(jcpp_pkg::OP_SWD, 5'h0f, 32'h0);
    `CHK("swd_rd", rd_word[15:0], rsp[15:0])
    foreach (dq[i]) `CHK("swd_tdi", 1'b1, dq[i])
    cmd_swd_drive = 1;
    d = {rnd(), rnd(), rnd(), rnd()};
    run(jcpp_pkg::OP_SWD, 5'h1f, d);
    `CHK("swd_n", 32, mq.size())
    foreach (mq[i]) `CHK("swd_wr", d[i], mq[i])
    cmd_swd_drive = 0;
    swd_mode = 0;
    trace_en = 1;
    tick(2);
    for (int j = 0; j < 5; j++)
    begin
      tdiv = j[0] ? 8'h01 : 8'h04;
      tq.push_back(rnd());
      ub(tq[$], j[0] ? 2 : 4);
    end
    `CHK("overrun", 1'b1, tov)
    for (int i = 0; i < 4; i++)
    begin
      `CHK("tvalid", 1'b1, tv)
      `CHK("tdata", tq[i], tdat)
      trace_ready = 1;
      tick(1);
      trace_ready = 0;
    end
    `CHK("tvalid", 1'b0, tv)
    trace_en = 0;
    tick(2);
    `CHK("overrun", 1'b0, tov)
    results();
  end
endmodule : tb

// *** logic/jcpp_fifo.sv ***
`timescale 1ns/1ps
module jcpp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Synchronous reset
  input wire logic clk_en, // Freezes state when low
  jcpp_stream_if.fifo s // Write and read sides
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } jcpp_fifo_st_t;

  jcpp_fifo_st_t st_q;
  jcpp_fifo_st_t st_d;
  logic full;
  logic empty;
  logic wr;
  logic rd;

  assign full = (st_q.cnt == (PW+1)'(DEPTH));
  assign empty = (st_q.cnt == '0);
  assign s.wr_ready = clk_en && !full;
  assign s.rd_valid = clk_en && !empty;
  assign s.rd_data = st_q.mem[st_q.rp];
  assign wr = s.wr_valid && s.wr_ready;
  assign rd = s.rd_valid && s.rd_ready;

  always_comb
  begin
    st_d = st_q;
    if (wr)
    begin
      st_d.mem[st_q.wp] = s.wr_data;
      st_d.wp = st_q.wp + PW'(1);
    end
    if (rd)
    begin
      st_d.rp = st_q.rp + PW'(1);
    end
    st_d.cnt = st_q.cnt + (PW+1)'(wr) - (PW+1)'(rd);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  AST_FIFO_FULL_STALL: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && full && s.wr_valid && !rd) |=> (full && $stable(st_q.mem)))
    else $error("fifo accepts data while full");

endmodule : jcpp_fifo

// *** logic/jcpp_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Clock and mode parallel, data runs serially
// - Devices before target are configurable
// - Devices after target are configurable
// - Instruction bits before/after are summed lengths
// - Refuse total instruction length above 256; the 10-bit sum wraps, so totals of 1024 and up pass
// - Refuse more than 15 devices per side
// - System reset reaches every chained device
// - Probe drives clock, mode, data; target returns data
// - Optional active-low test port reset output
// - System reset held low as long as needed
// - Serial-wire mode uses clock and mode only
// - Capture UART trace on shared data-out pin
// - Buffer trace internally before host transfer
// - Trace path tops out near 2MB/s (divider floor of 2 at 40 MHz)
// - Reset line to target always driven
module jcpp_port (
  input wire logic clk, // Core clock, 40 MHz
  input wire logic reset_n, // Synchronous reset
  input wire logic clk_en, // Freezes all state when low
  input wire logic swd_mode, // Serial-wire mode select
  input wire logic cfg_valid, // Chain configuration strobe
  input wire logic [jcpp_pkg::DEV_W-1:0] cfg_dev_before, // Devices in front of target
  input wire logic [jcpp_pkg::DEV_W-1:0] cfg_dev_after, // Devices behind target
  input wire logic [jcpp_pkg::IRB_W-1:0] cfg_ir_before, // Instruction bits in front
  input wire logic [jcpp_pkg::IRB_W-1:0] cfg_ir_after, // Instruction bits behind
  input wire logic [jcpp_pkg::IRT_W-1:0] cfg_ir_target, // Target instruction length
  output logic cfg_ok, // Configuration accepted
  output logic cfg_err, // Configuration refused
  input wire logic cmd_valid, // Command request
  output logic cmd_ready, // Command taken
  input wire jcpp_pkg::jcpp_op_t cmd_op, // Command kind
  input wire logic cmd_swd_drive, // Serial-wire write, else read
  input wire logic [jcpp_pkg::LEN_W-1:0] cmd_len, // Payload bits minus one
  input wire logic [jcpp_pkg::DATA_W-1:0] cmd_data, // Payload, lsb first
  output logic rsp_valid, // Command finished pulse
  output logic [jcpp_pkg::DATA_W-1:0] rsp_data, // Captured payload
  input wire logic sys_reset_req, // Hold target in reset
  input wire logic tap_reset_req, // Hold test port in reset
  output logic tck_out, // Test clock pin
  output logic tms_out, // Mode select / data pin drive
  output logic tms_oe, // Mode select pin enable
  input wire logic tms_in, // Mode select / data pin level
  output logic tdi_out, // Serial data to chain
  input wire logic tdo_in, // Serial data / trace from chain
  output logic tap_reset_out_n, // Test port reset pin
  output logic system_reset_out_n, // System reset pin
  input wire logic trace_en, // Trace capture enable
  input wire logic [jcpp_pkg::TDIV_W-1:0] trace_div, // Clocks per trace bit
  output logic trace_valid, // Trace byte available
  input wire logic trace_ready, // Host takes trace byte
  output logic [jcpp_pkg::BYTE_W-1:0] trace_data, // Trace byte
  output logic trace_overrun // Trace byte lost
);

  typedef struct packed {
    jcpp_pkg::jcpp_state_t state;
    jcpp_pkg::jcpp_op_t op;
    logic [jcpp_pkg::DIV_W-1:0] div;
    logic tck;
    logic tms;
    logic tms_oe;
    logic tdi;
    logic [7:0] pat;
    logic [jcpp_pkg::HIDX_W-1:0] hidx;
    logic [jcpp_pkg::HIDX_W-1:0] hlast;
    logic [jcpp_pkg::IDX_W-1:0] idx;
    logic [jcpp_pkg::IDX_W-1:0] chk;
    logic drive;
    logic [jcpp_pkg::LEN_W-1:0] len;
    logic [jcpp_pkg::DATA_W-1:0] data;
    logic [jcpp_pkg::DATA_W-1:0] rx;
    logic rsp;
    logic [jcpp_pkg::DEV_W-1:0] dev_b;
    logic [jcpp_pkg::DEV_W-1:0] dev_a;
    logic [jcpp_pkg::IRB_W-1:0] ir_b;
    logic [jcpp_pkg::IRB_W-1:0] ir_a;
    logic [jcpp_pkg::IRT_W-1:0] ir_t;
    logic ok;
    logic err;
    logic tdo_s1;
    logic tdo_s2;
    logic tms_s1;
    logic tms_s2;
    logic srst_n;
    logic trst_n;
    jcpp_pkg::jcpp_rx_t ust;
    logic [jcpp_pkg::TDIV_W-1:0] ucnt;
    logic [2:0] ubits;
    logic [jcpp_pkg::BYTE_W-1:0] ushift;
    logic overrun;
  } jcpp_st_t;

  localparam jcpp_st_t ST_RST = '{
    state: jcpp_pkg::ST_IDLE,
    op: jcpp_pkg::OP_TAP_RESET,
    ust: jcpp_pkg::RX_IDLE,
    tms_oe: 1'b1,
    tdi: 1'b1,
    tdo_s1: 1'b1,
    tdo_s2: 1'b1,
    tms_s1: 1'b1,
    tms_s2: 1'b1,
    srst_n: 1'b1,
    trst_n: 1'b1,
    default: '0
  };

  jcpp_st_t st_q;
  jcpp_st_t st_d;
  jcpp_stream_if #(.WIDTH(jcpp_pkg::BYTE_W)) trace_s ();

  logic jtag;
  logic tick;
  logic [jcpp_pkg::IDX_W-1:0] pre;
  logic [jcpp_pkg::IDX_W-1:0] post;
  logic [jcpp_pkg::IDX_W-1:0] tgt_hi;
  logic [jcpp_pkg::IDX_W-1:0] total;
  logic [jcpp_pkg::IDX_W-1:0] ir_sum;
  logic [jcpp_pkg::TDIV_W-1:0] udiv;
  logic cfg_take;
  logic cfg_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Chain geometry: padding first reaches the devices nearest the return pin
  assign jtag = (st_q.op != jcpp_pkg::OP_SWD);
  assign pre = !jtag ? '0 : (st_q.op == jcpp_pkg::OP_IR) ? jcpp_pkg::IDX_W'(st_q.ir_a)
    : jcpp_pkg::IDX_W'(st_q.dev_a);
  assign post = !jtag ? '0 : (st_q.op == jcpp_pkg::OP_IR) ? jcpp_pkg::IDX_W'(st_q.ir_b)
    : jcpp_pkg::IDX_W'(st_q.dev_b);
  assign tgt_hi = pre + jcpp_pkg::IDX_W'(st_q.len) + jcpp_pkg::IDX_W'(1);
  assign total = tgt_hi + post;
  assign tick = (st_q.div == jcpp_pkg::DIV_W'(jcpp_pkg::TCK_HALF_CYC - 1));

  assign ir_sum = jcpp_pkg::IDX_W'(cfg_ir_before) + jcpp_pkg::IDX_W'(cfg_ir_after)
    + jcpp_pkg::IDX_W'(cfg_ir_target);
  assign cfg_take = cfg_valid && (st_q.state == jcpp_pkg::ST_IDLE);
  assign cfg_bad = (cfg_dev_before > jcpp_pkg::DEV_MAX) || (cfg_dev_after > jcpp_pkg::DEV_MAX)
    || (ir_sum > jcpp_pkg::IR_TOTAL_MAX) || (cfg_ir_target == '0);

  assign cmd_ready = clk_en && (st_q.state == jcpp_pkg::ST_IDLE) && !cfg_valid
    && (swd_mode ? (cmd_op == jcpp_pkg::OP_SWD) : (st_q.ok && cmd_op != jcpp_pkg::OP_SWD));

  assign udiv = (trace_div < jcpp_pkg::TRACE_MIN_DIV) ? jcpp_pkg::TRACE_MIN_DIV : trace_div;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic load;
    logic [jcpp_pkg::IDX_W-1:0] off;
    load = 1'b0;
    off = '0;
    st_d = st_q;
    st_d.rsp = 1'b0;
    st_d.tdo_s1 = tdo_in;
    st_d.tdo_s2 = st_q.tdo_s1;
    st_d.tms_s1 = tms_in;
    st_d.tms_s2 = st_q.tms_s1;
    st_d.srst_n = !sys_reset_req;
    st_d.trst_n = !tap_reset_req;

    if (cfg_take)
    begin
      st_d.ok = !cfg_bad;
      st_d.err = cfg_bad;
      if (!cfg_bad)
      begin
        st_d.dev_b = cfg_dev_before;
        st_d.dev_a = cfg_dev_after;
        st_d.ir_b = cfg_ir_before;
        st_d.ir_a = cfg_ir_after;
        st_d.ir_t = cfg_ir_target;
      end
    end

    unique case (st_q.state)
      jcpp_pkg::ST_IDLE:
      begin
        st_d.div = '0;
        st_d.tck = 1'b0;
        st_d.tdi = 1'b1;
        st_d.tms = 1'b0;
        st_d.tms_oe = 1'b1;
        if (cmd_valid && cmd_ready)
        begin
          st_d.op = cmd_op;
          st_d.drive = cmd_swd_drive;
          st_d.len = (cmd_op == jcpp_pkg::OP_IR) ? jcpp_pkg::LEN_W'(st_q.ir_t - 1'b1) : cmd_len;
          st_d.data = cmd_data;
          st_d.rx = '0;
          st_d.idx = '0;
          st_d.chk = '0;
          st_d.hidx = '0;
          unique case (cmd_op)
            jcpp_pkg::OP_SWD:
            begin
              st_d.state = jcpp_pkg::ST_SHIFT;
              load = 1'b1;
            end
            jcpp_pkg::OP_IR:
            begin
              st_d.state = jcpp_pkg::ST_HEAD;
              st_d.pat = jcpp_pkg::HEAD_IR;
              st_d.hlast = jcpp_pkg::HEAD_IR_LAST;
            end
            jcpp_pkg::OP_DR:
            begin
              st_d.state = jcpp_pkg::ST_HEAD;
              st_d.pat = jcpp_pkg::HEAD_DR;
              st_d.hlast = jcpp_pkg::HEAD_DR_LAST;
            end
            jcpp_pkg::OP_TAP_RESET:
            begin
              st_d.state = jcpp_pkg::ST_HEAD;
              st_d.pat = jcpp_pkg::HEAD_RST;
              st_d.hlast = jcpp_pkg::HEAD_RST_LAST;
            end
          endcase
          st_d.tms = st_d.pat[0];
        end
      end
      default:
      begin
        st_d.div = tick ? '0 : st_q.div + jcpp_pkg::DIV_W'(1);
        if (tick && !st_q.tck)
        begin
          // Rising edge: the chain samples, the probe captures the return bit
          st_d.tck = 1'b1;
          if (st_q.state == jcpp_pkg::ST_SHIFT)
          begin
            st_d.chk = st_q.chk + jcpp_pkg::IDX_W'(1);
            if (!jtag && !st_q.drive)
            begin
              st_d.rx[st_q.idx[jcpp_pkg::LEN_W-1:0]] = st_q.tms_s2;
            end
            else if (jtag && st_q.idx >= pre && st_q.idx < tgt_hi)
            begin
              off = st_q.idx - pre;
              st_d.rx[off[jcpp_pkg::LEN_W-1:0]] = st_q.tdo_s2;
            end
          end
        end
        else if (tick)
        begin
          // Falling edge: move to the next bit
          st_d.tck = 1'b0;
          unique case (st_q.state)
            jcpp_pkg::ST_HEAD:
            begin
              if (st_q.hidx == st_q.hlast)
              begin
                if (st_q.op == jcpp_pkg::OP_TAP_RESET)
                begin
                  st_d.state = jcpp_pkg::ST_IDLE;
                  st_d.rsp = 1'b1;
                end
                else
                begin
                  st_d.state = jcpp_pkg::ST_SHIFT;
                  st_d.idx = '0;
                  load = 1'b1;
                end
              end
              else
              begin
                st_d.hidx = st_q.hidx + jcpp_pkg::HIDX_W'(1);
                st_d.tms = st_q.pat[st_d.hidx];
              end
            end
            jcpp_pkg::ST_SHIFT:
            begin
              if (st_q.idx == total - jcpp_pkg::IDX_W'(1))
              begin
                if (jtag)
                begin
                  st_d.state = jcpp_pkg::ST_TAIL;
                  st_d.hidx = '0;
                  st_d.tms = jcpp_pkg::TAIL_PAT[0];
                  st_d.tdi = 1'b1;
                end
                else
                begin
                  st_d.state = jcpp_pkg::ST_IDLE;
                  st_d.rsp = 1'b1;
                end
              end
              else
              begin
                st_d.idx = st_q.idx + jcpp_pkg::IDX_W'(1);
                load = 1'b1;
              end
            end
            jcpp_pkg::ST_TAIL:
            begin
              if (st_q.hidx == jcpp_pkg::TAIL_LAST)
              begin
                st_d.state = jcpp_pkg::ST_IDLE;
                st_d.rsp = 1'b1;
              end
              else
              begin
                st_d.hidx = st_q.hidx + jcpp_pkg::HIDX_W'(1);
                st_d.tms = jcpp_pkg::TAIL_PAT[st_d.hidx];
              end
            end
            default:
            begin
              st_d.state = jcpp_pkg::ST_IDLE;
            end
          endcase
        end
      end
    endcase

    // Present the bit at st_d.idx
    if (load)
    begin
      if (st_d.op == jcpp_pkg::OP_SWD)
      begin
        st_d.tdi = 1'b1;
        st_d.tms_oe = st_d.drive;
        st_d.tms = st_d.drive & st_d.data[st_d.idx[jcpp_pkg::LEN_W-1:0]];
      end
      else
      begin
        off = st_d.idx - pre;
        st_d.tdi = (st_d.idx >= pre && st_d.idx < tgt_hi) ? st_d.data[off[jcpp_pkg::LEN_W-1:0]]
          : 1'b1;
        st_d.tms = (st_d.idx == total - jcpp_pkg::IDX_W'(1));
      end
    end

    // Trace receiver on the shared data-out pin
    unique case (st_q.ust)
      jcpp_pkg::RX_IDLE:
      begin
        if (!st_q.tdo_s2)
        begin
          st_d.ust = jcpp_pkg::RX_START;
          st_d.ucnt = (udiv >> 1) - jcpp_pkg::TDIV_W'(1);
        end
      end
      jcpp_pkg::RX_START:
      begin
        st_d.ucnt = st_q.ucnt - jcpp_pkg::TDIV_W'(1);
        if (st_q.ucnt == '0)
        begin
          st_d.ust = st_q.tdo_s2 ? jcpp_pkg::RX_IDLE : jcpp_pkg::RX_DATA;
          st_d.ucnt = udiv - jcpp_pkg::TDIV_W'(1);
          st_d.ubits = '0;
        end
      end
      jcpp_pkg::RX_DATA:
      begin
        st_d.ucnt = st_q.ucnt - jcpp_pkg::TDIV_W'(1);
        if (st_q.ucnt == '0)
        begin
          st_d.ushift = {st_q.tdo_s2, st_q.ushift[jcpp_pkg::BYTE_W-1:1]};
          st_d.ucnt = udiv - jcpp_pkg::TDIV_W'(1);
          st_d.ubits = st_q.ubits + 3'h1;
          if (st_q.ubits == jcpp_pkg::TRACE_LAST_BIT)
          begin
            st_d.ust = jcpp_pkg::RX_STOP;
          end
        end
      end
      jcpp_pkg::RX_STOP:
      begin
        st_d.ucnt = st_q.ucnt - jcpp_pkg::TDIV_W'(1);
        if (st_q.ucnt == '0)
        begin
          st_d.ust = jcpp_pkg::RX_IDLE;
        end
      end
    endcase
    if (trace_s.wr_valid && !trace_s.wr_ready)
    begin
      st_d.overrun = 1'b1;
    end
    if (!trace_en)
    begin
      st_d.ust = jcpp_pkg::RX_IDLE;
      st_d.overrun = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q <= ST_RST;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trace buffer
  assign trace_s.wr_valid = trace_en && (st_q.ust == jcpp_pkg::RX_STOP) && (st_q.ucnt == '0)
    && st_q.tdo_s2;
  assign trace_s.wr_data = st_q.ushift;
  assign trace_s.rd_ready = trace_ready;
  assign trace_valid = trace_s.rd_valid;
  assign trace_data = trace_s.rd_data;

  jcpp_fifo #(.WIDTH(jcpp_pkg::BYTE_W), .DEPTH(jcpp_pkg::FIFO_DEPTH)) u_trace_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .s(trace_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cfg_ok = st_q.ok;
  assign cfg_err = st_q.err;
  assign rsp_valid = st_q.rsp;
  assign rsp_data = st_q.rx;
  assign tck_out = st_q.tck;
  assign tms_out = st_q.tms;
  assign tms_oe = st_q.tms_oe;
  assign tdi_out = st_q.tdi;
  assign tap_reset_out_n = st_q.trst_n;
  assign system_reset_out_n = st_q.srst_n;
  assign trace_overrun = st_q.overrun;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CFG_DEV_LIMIT: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && cfg_take && (cfg_dev_before > jcpp_pkg::DEV_MAX || cfg_dev_after > jcpp_pkg::DEV_MAX))
    |=> (cfg_err && !cfg_ok))
    else $error("device count above limit was accepted");

  AST_CFG_IR_LIMIT: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && cfg_take && ir_sum > jcpp_pkg::IR_TOTAL_MAX) |=> (cfg_err && !cfg_ok))
    else $error("instruction length above limit was accepted");

  AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == jcpp_pkg::ST_SHIFT && st_d.state == jcpp_pkg::ST_TAIL && clk_en) |-> (st_q.chk == total))
    else $error("shift length differs from padded chain length");

  AST_PAD_ONES: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == jcpp_pkg::ST_SHIFT && jtag && (st_q.idx < pre || st_q.idx >= tgt_hi)) |-> tdi_out)
    else $error("padding bit is not a one");

  AST_EXIT_TMS: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == jcpp_pkg::ST_SHIFT && jtag) |-> (tms_out == (st_q.idx == total - jcpp_pkg::IDX_W'(1))))
    else $error("mode select wrong during shift");

  AST_SRST_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && sys_reset_req) ##1 (clk_en && sys_reset_req) |=> !system_reset_out_n)
    else $error("system reset released while requested");

  AST_TRST_FOLLOW: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> (tap_reset_out_n == !$past(tap_reset_req)))
    else $error("test port reset does not follow request");

  AST_SWD_PINS: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == jcpp_pkg::ST_SHIFT && !jtag) |-> (tdi_out && tms_oe == st_q.drive))
    else $error("serial-wire shift uses wrong pins");

  AST_TRACE_LOSS: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && trace_en && trace_s.wr_valid && !trace_s.wr_ready) |=> trace_overrun)
    else $error("lost trace byte not flagged");

endmodule : jcpp_port
